// ---- data_space_access_checker_bench.sv ----
// self-checking bench for the data space access checker
`timescale 1ns/1ps
module data_space_access_checker_bench;
	reg SYS_CLK, RST, x_req, x_wr, x_byte, x_mac, y_req, sp_wr, lim_wr;
	reg [1:0] x_mode, stk_op, push_kind;
	reg [15:0] x_base, y_addr, push_data, sw_wdata, a, x_wdata, w_old;
	reg [7:0] st_low;
	wire [15:0] xrr, yrr, r_addr, r_wdata, x_rdata, w_load, y_rdata, p_next, sp_out, lim_out;
	wire [15:0] y_raddr;
	wire [1:0] r_we;
	wire r_re, a_err, s_err;
	integer failures = 0, total_checks = 0, cycles = 0, i;
	dsac_access_checker u_dut (.SYS_CLK(SYS_CLK), .RST(RST), .X_REQ(x_req), .X_WRITE(x_wr),
		.X_BYTE(x_byte), .X_MODE(x_mode), .X_BASE(x_base), .X_MAC(x_mac), .X_WDATA(x_wdata),
		.X_RAM_RDATA(xrr), .Y_REQ(y_req), .Y_ADDR(y_addr), .Y_RAM_RDATA(yrr), .WREG_OLD(w_old),
		.STK_OP(stk_op), .PUSH_KIND(push_kind), .PUSH_DATA(push_data), .STATUS_LOW(st_low),
		.SP_WR(sp_wr), .LIM_WR(lim_wr), .SW_WDATA(sw_wdata), .X_RAM_ADDR(r_addr), .X_RAM_WE(r_we),
		.X_RAM_WDATA(r_wdata), .X_RAM_RE(r_re), .Y_RAM_ADDR(y_raddr), .X_RDATA(x_rdata),
		.WREG_LOAD(w_load), .Y_RDATA(y_rdata), .PTR_NEXT(p_next), .SP_OUT(sp_out),
		.LIM_OUT(lim_out), .ADDR_ERR(a_err), .STK_ERR(s_err));
	dsac_ram_model u_ram (.x_addr(r_addr), .x_re(r_re), .y_addr(y_addr), .y_req(y_req),
		.x_rdata(xrr), .y_rdata(yrr));
	task check(input [15:0] seen, input [15:0] exp, input [63:0] nm);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("wrong value %0s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task step;
		begin
			@(posedge SYS_CLK);
			#1;
		end
	endtask
	// each request waits an edge first, so no strobe rises in the step it fell
	task xop(input w, input b, input [1:0] m, input [15:0] ad, input mac);
		begin
			step;
			{x_req, x_wr, x_byte, x_mode, x_base, x_mac} = {1'b1, w, b, m, ad, mac};
			step;
			x_req = 1'b0;
		end
	endtask
	task sop(input [1:0] op, input [1:0] kind, input [15:0] d);
		begin
			step;
			{stk_op, push_kind, push_data} = {op, kind, d};
			step;
			stk_op = 2'h0;
		end
	endtask
	task swr(input lim, input [15:0] d);
		begin
			step;
			{lim_wr, sp_wr, sw_wdata} = {lim, !lim, d};
			step;
			{lim_wr, sp_wr} = 2'h0;
			repeat (3) step;
		end
	endtask
	function [15:0] pat(input [15:0] ad);
		pat = ad ^ 16'h5a3c;
	endfunction
	task end_of_test;
		begin
			$display("checks %0d failures %0d", total_checks, failures);
			if (failures == 0 && total_checks > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	initial begin
		SYS_CLK = 1'b0;
		forever #12.5 SYS_CLK = ~SYS_CLK;
	end
	// hang guard, the run needs well under a thousand cycles
	always @(posedge SYS_CLK) begin
		cycles = cycles + 1;
		if (cycles == 3000) begin
			failures = failures + 1;
			end_of_test;
		end
	end
	initial begin
		{RST, x_req, x_wr, x_byte, x_mac, y_req, sp_wr, lim_wr} = 8'h80;
		{x_mode, stk_op, push_kind, x_base, y_addr, push_data, sw_wdata, a} = 0;
		i = $urandom(32'h5f9e);
		x_wdata = $urandom;
		w_old = $urandom;
		st_low = $urandom;
		repeat (8) @(posedge SYS_CLK);
		#1 RST = 1'b0;
		check(sp_out, 16'h0800, "sp_rst");
		// random reads: composite space, then mac reads into x and into the y block
		for (i = 0; i < 18; i = i + 1) begin
			a = i < 6 ? $urandom & 16'h0bfe : i < 12 ? $urandom & 16'h07fe : $urandom & 16'h03fe | 16'h0800;
			xop(1'b0, 1'b0, 2'h2, a, i >= 6);
			if (i < 12) check(r_addr, a, "x_addr");
			step;
			check(x_rdata, i < 12 ? pat(a) : 16'h0000, "x_rdata");
		end
		xop(1'b0, 1'b0, 2'h2, 16'h2000, 1'b0);
		step;
		check(x_rdata, 16'h0000, "unimpl");
		a = pat(16'h0802);
		xop(1'b0, 1'b1, 2'h2, 16'h0803, 1'b0);
		step;
		check(x_rdata[7:0], a[15:8], "b_rdata");
		check(w_load, {w_old[15:8], a[15:8]}, "w_load");
		for (i = 0; i < 4; i = i + 1) begin
			xop(1'b1, i < 2, 2'h2, 16'h0804 + i[0], 1'b0);
			check(r_we, i < 2 ? (i ? 2'h2 : 2'h1) : (i == 2 ? 2'h3 : 2'h0), "lanes");
			check(r_wdata, i < 2 ? {2{x_wdata[7:0]}} : x_wdata, "wdata");
			check(a_err, i == 3, "a_err");
		end
		xop(1'b0, 1'b0, 2'h2, 16'h0807, 1'b0);
		check({a_err, r_re}, 2'h3, "rd_err");
		step;
		check(a_err, 1'b0, "err_pls");
		for (i = 0; i < 2; i = i + 1) begin
			xop(1'b0, !i, 2'h3, 16'h0810, 1'b0);
			check(p_next, 16'h0811 + i, "p_next");
		end
		xop(1'b0, 1'b0, 2'h1, 16'he010, 1'b0);
		check(r_addr, 16'h0010, "near");
		xop(1'b0, 1'b0, 2'h0, 16'ha000, 1'b0);
		check(r_addr, 16'ha000, "direct");
		for (i = 0; i < 2; i = i + 1) begin
			step;
			{y_req, y_addr} = {1'b1, i ? 16'h0100 : 16'h0900};
			step;
			check(y_raddr, y_addr, "y_raddr");
			y_req = 1'b0;
			step;
			check(y_rdata, i ? 16'h0000 : pat(16'h0900), "y_rdata");
		end
		swr(1'b1, 16'h0803);
		check(lim_out, 16'h0802, "limit");
		sop(2'h1, 2'h0, 16'hffff);
		check(r_addr, 16'h0800, "psh_adr");
		check(r_wdata, 16'h7fff, "call");
		step;
		check(sp_out, 16'h0802, "sp_inc");
		sop(2'h1, 2'h1, 16'h1234);
		check({s_err, r_we}, 3'h3, "at_lim");
		check(r_wdata, {st_low, 8'h34}, "exc");
		for (i = 0; i < 3; i = i + 1) begin
			sop(2'h2, 2'h0, 16'h0000);
			check(s_err, i == 2, "under");
			if (i < 2) check(r_addr, 16'h0802 - 2 * i, "pop_adr");
		end
		swr(1'b0, 16'h0804);
		sop(2'h1, 2'h2, 16'h5555);
		check({s_err, r_we}, 3'h4, "over");
		// reset again mid-run: the pointer returns home, the limit keeps its value
		step;
		RST = 1'b1;
		repeat (2) step;
		RST = 1'b0;
		check(sp_out, 16'h0800, "sp_rst2");
		step;
		check(lim_out, 16'h0802, "lim_keep");
		end_of_test;
	end
endmodule

// ---- dsac_access_checker.v ----
// data space access checker: addressing, lanes, alignment and stack checks
`timescale 1ns/1ps
`include "dsac_defines.vh"
module dsac_access_checker (
	input wire SYS_CLK, // core instruction clock
	input wire RST, // sync reset, active high
	input wire X_REQ, // x access valid this cycle
	input wire X_WRITE, // 1 write, 0 read
	input wire X_BYTE, // byte-sized access
	input wire [1:0] X_MODE, // addressing mode
	input wire [15:0] X_BASE, // pointer or absolute field
	input wire X_MAC, // dual_operand_mac_class fetch
	input wire [15:0] X_WDATA, // write data
	input wire [15:0] X_RAM_RDATA, // word from ram on x port
	input wire Y_REQ, // y fetch valid (mac only)
	input wire [15:0] Y_ADDR, // address from y_pointer_a/b
	input wire [15:0] Y_RAM_RDATA, // word from ram on y port
	input wire [15:0] WREG_OLD, // current content of load target
	input wire [1:0] STK_OP, // none, push or pop
	input wire [1:0] PUSH_KIND, // call, exception or data push
	input wire [15:0] PUSH_DATA, // data word or pc word to push
	input wire [7:0] STATUS_LOW, // status_low_reg value
	input wire SP_WR, // software write of stack pointer
	input wire LIM_WR, // software write of stack limit
	input wire [15:0] SW_WDATA, // value for those writes
	output reg [15:0] X_RAM_ADDR, // word-aligned ram address
	output reg [1:0] X_RAM_WE, // byte lane write strobes
	output reg [15:0] X_RAM_WDATA, // data to ram
	output reg X_RAM_RE, // ram read enable
	output reg [15:0] Y_RAM_ADDR, // y ram word address
	output reg [15:0] X_RDATA, // x read result
	output reg [15:0] WREG_LOAD, // merged register load value
	output reg [15:0] Y_RDATA, // y read result
	output reg [15:0] PTR_NEXT, // updated pointer after post-increment
	output reg [15:0] SP_OUT, // stack pointer
	output reg [15:0] LIM_OUT, // stack limit
	output reg ADDR_ERR, // address error trap pulse
	output reg STK_ERR // stack error trap pulse
);
	reg [15:0] stack_pointer_reg;
	reg [15:0] stack_limit_reg;
	reg [15:0] ea;
	reg [15:0] sp_next;
	reg [15:0] stk_ea;
	reg [15:0] push_word;
	reg misalign;
	reg valid_x;
	reg stk_fault;
	reg rd_byte_reg;
	reg rd_hi_reg;
	reg rd_ok_reg;
	reg rd_pend_reg;
	wire [15:0] y_word;
	wire y_mis;

	// true when an address is backed by ram
	// everything above the top of ram reads as zero instead of faulting
	function implemented;
		input [15:0] a;
		begin
			implemented = (a <= `DSAC_RAM_TOP);
		end
	endfunction

	// true when an address falls in the y block
	function in_y;
		input [15:0] a;
		begin
			in_y = (a >= `DSAC_Y_BASE) && (a <= `DSAC_Y_TOP);
		end
	endfunction

	// clears bit 0 so the ram sees the word that holds the byte
	function [15:0] word_align;
		input [15:0] a;
		begin
			word_align = {a[`DSAC_WORD_BITS], 1'b0};
		end
	endfunction

	// picks the addressed byte of a word; bit 0 of the address says which half
	function [7:0] pick_byte;
		input [15:0] w;
		input hi;
		begin
			pick_byte = hi ? w[`DSAC_HI_BYTE] : w[`DSAC_LO_BYTE];
		end
	endfunction

	// one strobe per lane; a byte write must never touch the other half
	function [1:0] lane_strobe;
		input hi;
		begin
			lane_strobe = hi ? `DSAC_WE_HIGH : `DSAC_WE_LOW;
		end
	endfunction

	// effective address by mode; near field keeps only 13 bits
	// the near mask folds any address above 8 KB back into the window
	always @* begin
		case (X_MODE)
			`DSAC_MODE_NEAR: ea = X_BASE & `DSAC_NEAR_TOP;
			`DSAC_MODE_DIRECT: ea = X_BASE;
			default: ea = X_BASE; // indirect and post-increment use pointer value
		endcase
	end

	// push stores at pointer, pop reads one word below it
	// the pop check looks at the word it will read, not at the pointer
	always @* begin
		sp_next = stack_pointer_reg;
		stk_ea = stack_pointer_reg;
		case (STK_OP)
			`DSAC_STK_PUSH: begin
				stk_ea = stack_pointer_reg;
				sp_next = stack_pointer_reg + `DSAC_STEP_WORD;
			end
			`DSAC_STK_POP: begin
				stk_ea = stack_pointer_reg - `DSAC_STEP_WORD;
				sp_next = stk_ea;
			end
			default: begin
				sp_next = stack_pointer_reg;
			end
		endcase
	end

	// the pushed word depends on who pushes
	always @* begin
		case (PUSH_KIND)
			`DSAC_PUSH_CALL: push_word = {1'b0, PUSH_DATA[`DSAC_PC_LOW]};
			`DSAC_PUSH_EXC: push_word = {STATUS_LOW, PUSH_DATA[`DSAC_LO_BYTE]};
			default: push_word = PUSH_DATA;
		endcase
	end

	// equal-to-limit push is legal; only past the limit or under the floor traps
	always @* begin
		stk_fault = 1'b0;
		if (STK_OP != `DSAC_STK_NONE) begin
			stk_fault = (stk_ea > stack_limit_reg) ||
				(stk_ea < `DSAC_STACK_BOTTOM);
		end
		// flagged even when a stack op takes the port, so the dropped access still traps
		misalign = X_REQ && !X_BYTE && ea[0];
		// mac x pointers may not see the y block
		valid_x = implemented(ea) && !(X_MAC && in_y(ea));
	end

	// the y path is kept apart so a mac fetch can read both spaces at once
	dsac_yread u_yread (
		.clk(SYS_CLK),
		.rst(RST),
		.en(Y_REQ),
		.addr(Y_ADDR),
		.ram_data(Y_RAM_RDATA),
		.data_reg(y_word),
		.misalign_reg(y_mis)
	);

	// stack pointer and limit; limit has no reset value by design
	// until software writes the limit every stack check sees an unknown value
	always @(posedge SYS_CLK) begin
		if (RST) begin
			stack_pointer_reg <= `DSAC_SP_RESET;
		end else if (SP_WR) begin
			stack_pointer_reg <= word_align(SW_WDATA);
		end else begin
			// the pointer moves even on a faulting access; the trap handler sorts it out
			stack_pointer_reg <= sp_next;
		end
		if (LIM_WR) begin
			stack_limit_reg <= word_align(SW_WDATA);
		end
	end

	// ram request side; one stack or x access per cycle, stack first
	always @(posedge SYS_CLK) begin
		if (RST) begin
			X_RAM_ADDR <= `DSAC_ZERO_WORD;
			X_RAM_WE <= `DSAC_WE_NONE;
			X_RAM_WDATA <= `DSAC_ZERO_WORD;
			X_RAM_RE <= 1'b0;
			Y_RAM_ADDR <= `DSAC_ZERO_WORD;
			PTR_NEXT <= `DSAC_ZERO_WORD;
			rd_byte_reg <= 1'b0;
			rd_hi_reg <= 1'b0;
			rd_ok_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
		end else begin
			Y_RAM_ADDR <= word_align(Y_ADDR);
			rd_pend_reg <= 1'b0;
			X_RAM_WE <= `DSAC_WE_NONE;
			X_RAM_RE <= 1'b0;
			if (STK_OP == `DSAC_STK_PUSH) begin
				X_RAM_ADDR <= stk_ea;
				X_RAM_WDATA <= push_word;
				X_RAM_WE <= stk_fault ? `DSAC_WE_NONE : `DSAC_WE_BOTH;
			end else if (STK_OP == `DSAC_STK_POP) begin
				X_RAM_ADDR <= stk_ea;
				X_RAM_RE <= 1'b1;
				rd_pend_reg <= 1'b1;
				rd_byte_reg <= 1'b0;
				rd_hi_reg <= 1'b0;
				rd_ok_reg <= implemented(stk_ea);
			end else if (X_REQ) begin
				X_RAM_ADDR <= word_align(ea);
				if (X_WRITE) begin
					// misaligned word writes are dropped, trap follows
					if (X_BYTE) begin
						X_RAM_WE <= lane_strobe(ea[0]);
						// the byte sits on both lanes so the strobe alone picks the half
						X_RAM_WDATA <= {2{X_WDATA[`DSAC_LO_BYTE]}};
					end else begin
						X_RAM_WE <= misalign ? `DSAC_WE_NONE : `DSAC_WE_BOTH;
						X_RAM_WDATA <= X_WDATA;
					end
				end else begin
					// misaligned reads still complete
					X_RAM_RE <= 1'b1;
					rd_pend_reg <= 1'b1;
					rd_byte_reg <= X_BYTE;
					rd_hi_reg <= ea[0];
					rd_ok_reg <= valid_x;
				end
			end
			// offered every cycle; the core only takes it in post-increment mode
			if (X_MODE == `DSAC_MODE_POSTINC) begin
				PTR_NEXT <= X_BASE + (X_BYTE ? `DSAC_STEP_BYTE : `DSAC_STEP_WORD);
			end else begin
				PTR_NEXT <= X_BASE;
			end
		end
	end

	// read return one cycle after the ram read; invalid reads give zero
	// the y result takes one more stage so both read paths line up for the core
	always @(posedge SYS_CLK) begin
		if (RST) begin
			X_RDATA <= `DSAC_ZERO_WORD;
			WREG_LOAD <= `DSAC_ZERO_WORD;
			Y_RDATA <= `DSAC_ZERO_WORD;
		end else begin
			Y_RDATA <= y_word;
			if (rd_pend_reg) begin
				if (!rd_ok_reg) begin
					X_RDATA <= `DSAC_ZERO_WORD;
					WREG_LOAD <= rd_byte_reg ? {WREG_OLD[`DSAC_HI_BYTE], `DSAC_ZERO_BYTE} :
						`DSAC_ZERO_WORD;
				end else if (rd_byte_reg) begin
					// byte goes to the low lane; upper byte of the target kept
					X_RDATA <= {`DSAC_ZERO_BYTE, pick_byte(X_RAM_RDATA, rd_hi_reg)};
					WREG_LOAD <= {WREG_OLD[`DSAC_HI_BYTE],
						pick_byte(X_RAM_RDATA, rd_hi_reg)};
				end else begin
					X_RDATA <= X_RAM_RDATA;
					WREG_LOAD <= X_RAM_RDATA;
				end
			end
		end
	end

	// trap pulses; the core takes the trap after the access it belongs to
	always @(posedge SYS_CLK) begin
		if (RST) begin
			ADDR_ERR <= 1'b0;
			STK_ERR <= 1'b0;
		end else begin
			// a y misalign arrives one cycle after an x misalign of the same fetch
			ADDR_ERR <= misalign || y_mis;
			STK_ERR <= stk_fault;
		end
	end

	// pointer and limit copies for the core; the limit copy reads zero only in reset
	always @(posedge SYS_CLK) begin
		if (RST) begin
			SP_OUT <= `DSAC_SP_RESET;
			LIM_OUT <= `DSAC_ZERO_WORD;
		end else begin
			SP_OUT <= stack_pointer_reg;
			LIM_OUT <= stack_limit_reg;
		end
	end
endmodule

// ---- dsac_access_monitor.sv ----
// assertion checker bound to the access checker
`timescale 1ns/1ps
module dsac_access_monitor (
	input wire SYS_CLK, // clock
	input wire RST, // reset
	input wire X_REQ, // x access
	input wire X_WRITE, // write
	input wire X_BYTE, // byte
	input wire [1:0] X_MODE, // mode
	input wire [15:0] X_BASE, // address
	input wire [1:0] STK_OP, // stack op
	input wire Y_REQ, // y fetch
	input wire [15:0] Y_ADDR, // y address
	input wire [1:0] X_RAM_WE, // strobes
	input wire [15:0] X_RDATA, // x data
	input wire [15:0] Y_RDATA, // y data
	input wire [15:0] PTR_NEXT, // pointer
	input wire [15:0] SP_OUT, // stack pointer
	input wire ADDR_ERR, // address trap
	input wire STK_ERR // stack trap
);
	default clocking mon_cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);
	// stack ops win the port, so plain x checks skip those cycles
	wire x_ind = X_REQ && STK_OP == 2'h0 && X_MODE == 2'h2;
	byte_lane_a: assert property (x_ind && X_WRITE && X_BYTE |=>
		X_RAM_WE == {$past(X_BASE[0]), !$past(X_BASE[0])}) else $error("bad lane");
	misalign_trap_a: assert property (x_ind && !X_BYTE && X_BASE[0] |=>
		ADDR_ERR && X_RAM_WE == 2'h0) else $error("no align trap");
	postinc_step_a: assert property (X_REQ && STK_OP == 2'h0 && X_MODE == 2'h3 |=>
		PTR_NEXT == $past(X_BASE) + ($past(X_BYTE) ? 16'h0001 : 16'h0002)) else $error("bad step");
	unimpl_zero_a: assert property (x_ind && !X_WRITE && !X_BYTE && !X_BASE[0] &&
		X_BASE > 16'h0bff |=> ##1 X_RDATA == 16'h0000) else $error("unimpl not zero");
	y_xspace_a: assert property (Y_REQ && Y_ADDR < 16'h0800 |=> ##1 Y_RDATA == 16'h0000)
		else $error("y read of x space");
	stk_err_src_a: assert property (STK_ERR |-> $past(STK_OP) != 2'h0 && X_RAM_WE == 2'h0)
		else $error("stray stack trap");
	addr_err_src_a: assert property (ADDR_ERR |->
		($past(X_REQ) && !$past(X_BYTE)) || $past(Y_REQ, 2)) else $error("stray address trap");
	sp_reset_a: assert property ($fell(RST) |-> SP_OUT == 16'h0800 && !ADDR_ERR && !STK_ERR)
		else $error("bad reset state");
endmodule
bind dsac_access_checker dsac_access_monitor u_mon (.SYS_CLK(SYS_CLK), .RST(RST), .X_REQ(X_REQ),
	.X_WRITE(X_WRITE), .X_BYTE(X_BYTE), .X_MODE(X_MODE), .X_BASE(X_BASE), .STK_OP(STK_OP),
	.Y_REQ(Y_REQ), .Y_ADDR(Y_ADDR), .X_RAM_WE(X_RAM_WE), .X_RDATA(X_RDATA), .Y_RDATA(Y_RDATA),
	.PTR_NEXT(PTR_NEXT), .SP_OUT(SP_OUT), .ADDR_ERR(ADDR_ERR), .STK_ERR(STK_ERR));

// ---- dsac_defines.vh ----
// constants for the data space access checker
`ifndef DSAC_DEFINES_VH
`define DSAC_DEFINES_VH
`define DSAC_AW 16
`define DSAC_DW 16
`define DSAC_ZERO_WORD 16'h0000
`define DSAC_NEAR_TOP 16'h1fff
`define DSAC_STACK_BOTTOM 16'h0800
`define DSAC_SP_RESET 16'h0800
`define DSAC_STEP_BYTE 16'h0001
`define DSAC_STEP_WORD 16'h0002
`define DSAC_Y_BASE 16'h0800
`define DSAC_Y_TOP 16'h0bff
`define DSAC_RAM_TOP 16'h0bff
`define DSAC_MODE_DIRECT 2'h0
`define DSAC_MODE_NEAR 2'h1
`define DSAC_MODE_INDIRECT 2'h2
`define DSAC_MODE_POSTINC 2'h3
`define DSAC_STK_NONE 2'h0
`define DSAC_STK_PUSH 2'h1
`define DSAC_STK_POP 2'h2
`define DSAC_PUSH_CALL 2'h0
`define DSAC_PUSH_EXC 2'h1
`define DSAC_PUSH_DATA 2'h2
`define DSAC_HI_BYTE 15:8
`define DSAC_LO_BYTE 7:0
`define DSAC_WORD_BITS 15:1
`define DSAC_PC_LOW 14:0
`define DSAC_ZERO_BYTE 8'h00
`define DSAC_WE_NONE 2'h0
`define DSAC_WE_LOW 2'h1
`define DSAC_WE_HIGH 2'h2
`define DSAC_WE_BOTH 2'h3
`endif

// ---- dsac_ram_model.sv ----
// data ram stand-in for the x and y read ports
`timescale 1ns/1ps
module dsac_ram_model (
	input wire [15:0] x_addr, // x word address
	input wire x_re, // x read enable
	input wire [15:0] y_addr, // y address
	input wire y_req, // y fetch
	output wire [15:0] x_rdata, // x word
	output wire [15:0] y_rdata // y word
);
	// words follow the address so the bench can predict them; idle shows the inverse
	assign x_rdata = {16{!x_re}} ^ x_addr ^ 16'h5a3c;
	assign y_rdata = {16{!y_req}} ^ y_addr ^ 16'h5a3c;
endmodule

// ---- dsac_yread.v ----
// y read path: word-only fetch with space check
`timescale 1ns/1ps
`include "dsac_defines.vh"
module dsac_yread (
	input wire clk, // core clock
	input wire rst, // sync reset
	input wire en, // y fetch in a mac-class cycle
	input wire [15:0] addr, // effective address from a y pointer
	input wire [15:0] ram_data, // word from data ram
	output reg [15:0] data_reg, // fetched word, zero when invalid
	output reg misalign_reg // odd word address seen
);
	wire in_y = (addr >= `DSAC_Y_BASE) && (addr <= `DSAC_Y_TOP);
	// only whole words travel here; the low address bit never selects a byte
	always @(posedge clk) begin
		if (rst) begin
			data_reg <= `DSAC_ZERO_WORD;
			misalign_reg <= 1'b0;
		end else begin
			data_reg <= (en && in_y) ? ram_data : `DSAC_ZERO_WORD;
			misalign_reg <= en && addr[0];
		end
	end
endmodule
